// *** rtl/supply_monitor_pkg.sv ***
// Operation
// [RULE1] Every reset reloads trip level, active mode, sleep mode and sample rate from fuse.
// [RULE2] Trip level and active mode are read-only; only the fuse sets them.
// [RULE3] Writing one to the warning interrupt enable switches the early-warning monitor on.
// [RULE4] Request an interrupt when supply crosses the warning level in the chosen direction.
// [RULE5] Monitor follows the detector; detector off keeps monitor inactive despite the enable.
// [RULE6] In sampled mode the monitor is evaluated only at the detector sample instants.
// [RULE7] Enabling with either-direction sets the flag at once; single directions need not.
// [RULE8] Margin code 0 is 5%, 1 is 15%, 2 is 25% above trip level.
// [RULE9] In sampled mode only direction code 1 can raise a warning interrupt; the code also sets the flag when enabling with code 2.
// [RULE10] The configured warning condition sets the flag in the interrupt flag register.
// [RULE11] Request is high while enable and flag are set, until the flag clears.
// [RULE12] Debug halt leaves the detector running; only warning interrupt service stops.
// [RULE13] Entering standby or power-down switches the detector to the sleep mode field.
// [RULE14] Waking from standby or power-down returns the detector to the active mode field.
// [RULE15] Software writes the unlock key, then the sleep field within four instructions.
// [RULE16] Sleep field writes without the unlock sequence are accepted but change nothing.
// [RULE17] Active mode: 0 off, 1 on, 2 sampled, 3 on with wake held until ready.
// [RULE18] Sleep mode: 0 off, 1 on, 2 sampled; code 3 reserved.
// [RULE19] Sample rate bit clear gives 1 kHz sampling, set gives 125 Hz.
// [RULE20] Three-bit trip level code selects detector level; 2 is lower, 7 higher.
// [RULE21] Detector control runs from the slow low-power oscillator clock; the code runs it from core_clk_in, taken as 100 MHz.
// [RULE22] Direction: 0 falling crossing, 1 rising crossing, 2 either; others reserved.
// [RULE23] Flag and below state update only while the detector is enabled; one means below.
// [RULE24] Writing one to the flag clears it; zero does nothing; a new event wins.
package supply_monitor_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   localparam logic [3:0] OFS_DETECTOR_MODE_CONTROL     = 4'h0;
   localparam logic [3:0] OFS_DETECTOR_THRESHOLD        = 4'h1;
   localparam logic [3:0] OFS_MONITOR_LEVEL_CONTROL     = 4'h8;
   localparam logic [3:0] OFS_MONITOR_INTERRUPT_CONTROL = 4'h9;
   localparam logic [3:0] OFS_MONITOR_INTERRUPT_FLAG    = 4'hA;
   localparam logic [3:0] OFS_MONITOR_LEVEL_STATE       = 4'hB;

   // Field positions; sleep, active and rate bits are shared by the mode register and the fuse byte.
   localparam int unsigned SLEEP_LSB       = 0;
   localparam int unsigned ACTIVE_LSB      = 2;
   localparam int unsigned SAMPLE_RATE_BIT = 4;
   localparam int unsigned FUSE_LEVEL_LSB  = 5;
   localparam int unsigned LEVEL_LSB       = 0;
   localparam int unsigned MARGIN_LSB      = 0;
   localparam int unsigned IRQ_ENABLE_BIT  = 0;
   localparam int unsigned DIRECTION_LSB   = 1;
   localparam int unsigned FLAG_BIT        = 0;
   localparam int unsigned BELOW_BIT       = 0;

   localparam logic [1:0] MARGIN_RESET    = 2'h0;
   localparam logic [1:0] DIRECTION_RESET = 2'h0;

   typedef enum logic [1:0] {
      MODE_OFF     = 2'h0,
      MODE_ON      = 2'h1,
      MODE_SAMPLED = 2'h2,
      MODE_ON_WAIT = 2'h3
   } det_mode_type;

   typedef enum logic [1:0] {
      DIR_FALL   = 2'h0,
      DIR_RISE   = 2'h1,
      DIR_EITHER = 2'h2
   } direction_type;

   typedef enum logic [1:0] {
      MARGIN_5PCT  = 2'h0,
      MARGIN_15PCT = 2'h1,
      MARGIN_25PCT = 2'h2
   } margin_type;

   // Fuse capture sequence, Gray coded.
   typedef enum logic [1:0] {
      LOAD_SYNC1 = 2'h0,
      LOAD_SYNC2 = 2'h1,
      LOAD_TAKE  = 2'h3,
      RUN        = 2'h2
   } load_phase_type;

   localparam int unsigned CLK_FREQ_HZ         = 100_000_000;
   localparam int unsigned SAMPLE_FAST_HZ      = 1000;
   localparam int unsigned SAMPLE_SLOW_HZ      = 125;
   localparam int unsigned SAMPLE_FAST_CYCLES  = CLK_FREQ_HZ / SAMPLE_FAST_HZ;
   localparam int unsigned SAMPLE_SLOW_CYCLES  = CLK_FREQ_HZ / SAMPLE_SLOW_HZ;
   localparam int unsigned SAMPLE_CNT_W        = 20;
   localparam int unsigned UNLOCK_INSTRUCTIONS = 4;
   localparam logic [2:0]  UNLOCK_WINDOW       = 3'(UNLOCK_INSTRUCTIONS);
endpackage : supply_monitor_pkg

// *** rtl/supply_monitor_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_control
#(
   parameter int unsigned SAMPLE_FAST_CYCLES = supply_monitor_pkg::SAMPLE_FAST_CYCLES,
   parameter int unsigned SAMPLE_SLOW_CYCLES = supply_monitor_pkg::SAMPLE_SLOW_CYCLES
)
(
   input  wire logic       core_clk_in,
   input  wire logic       resetn_in,
   input  wire logic [7:0] detector_fuse_byte_in,
   input  wire logic       warn_below_raw_in,
   input  wire logic       detector_ready_raw_in,
   input  wire logic       deep_sleep_in,
   input  wire logic       debug_halt_in,
   input  wire logic       register_unlock_key_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_strobe_in,
   input  wire logic       rd_strobe_in,
   output logic      [7:0] rd_data_out,
   output logic            detector_enable_out,
   output logic            detector_sample_out,
   output logic      [2:0] trip_level_sel_out,
   output logic      [1:0] warn_margin_sel_out,
   output logic            warn_monitor_on_out,
   output logic            wake_hold_out,
   output logic            warn_irq_out
);

   // The clock is core_clk_in, taken as 100 MHz, not the slow low-power oscillator; its rate sets the sample counts. (see [RULE21])
   typedef struct packed {
      supply_monitor_pkg::load_phase_type phase;
      logic [7:0]                         fuse_meta;
      logic [7:0]                         fuse_sync;
      logic                               below_meta;
      logic                               below_sync;
      logic                               ready_meta;
      logic                               ready_sync;
      logic                               sample_rate;
      logic [1:0]                         active_mode;
      logic [1:0]                         sleep_mode;
      logic [2:0]                         trip_level;
      logic [1:0]                         margin;
      logic [1:0]                         direction;
      logic                               irq_enable;
      logic                               flag;
      logic                               below_state;
      logic [2:0]                         unlock_cnt;
      logic [supply_monitor_pkg::SAMPLE_CNT_W-1:0] sample_cnt;
      logic                               sample_pulse;
      logic                               in_sleep;
      logic                               wake_hold;
      logic                               det_active;
      logic                               mon_active;
      logic                               irq_req;
      logic [7:0]                         rd_data;
   } state_type;

   state_type s_ff;
   state_type nxt_s;

   logic [1:0]                                  cur_mode;
   logic                                        det_on;
   logic                                        sampled;
   logic                                        mon_on;
   logic                                        evaluate;
   logic                                        fell;
   logic                                        rose;
   logic                                        trigger;
   logic                                        enable_set;
   logic                                        flag_clear;
   logic                                        running;
   logic [supply_monitor_pkg::SAMPLE_CNT_W-1:0] sample_last;

   always_comb
   begin
      nxt_s = s_ff;
      running = (s_ff.phase == supply_monitor_pkg::RUN);

      nxt_s.fuse_meta  = detector_fuse_byte_in;
      nxt_s.fuse_sync  = s_ff.fuse_meta;
      nxt_s.below_meta = warn_below_raw_in;
      nxt_s.below_sync = s_ff.below_meta;
      nxt_s.ready_meta = detector_ready_raw_in;
      nxt_s.ready_sync = s_ff.ready_meta;

      // The fuse byte is taken only after it has passed the synchroniser. (see [RULE1])
      case (s_ff.phase)
         supply_monitor_pkg::LOAD_SYNC1:
         begin
            nxt_s.phase = supply_monitor_pkg::LOAD_SYNC2;
         end
         supply_monitor_pkg::LOAD_SYNC2:
         begin
            nxt_s.phase = supply_monitor_pkg::LOAD_TAKE;
         end
         supply_monitor_pkg::LOAD_TAKE:
         begin
            nxt_s.phase       = supply_monitor_pkg::RUN;
            nxt_s.sample_rate = s_ff.fuse_sync[supply_monitor_pkg::SAMPLE_RATE_BIT];
            nxt_s.active_mode = s_ff.fuse_sync[supply_monitor_pkg::ACTIVE_LSB +: 2];
            nxt_s.sleep_mode  = s_ff.fuse_sync[supply_monitor_pkg::SLEEP_LSB +: 2];
            nxt_s.trip_level  = s_ff.fuse_sync[supply_monitor_pkg::FUSE_LEVEL_LSB +: 3];
         end
         supply_monitor_pkg::RUN:
         begin
            nxt_s.phase = supply_monitor_pkg::RUN;
         end
         default:
         begin
            nxt_s.phase = supply_monitor_pkg::LOAD_SYNC1;
         end
      endcase

      // Sleep selects the sleep field, waking returns to the active field. (see [RULE13]) (see [RULE14])
      nxt_s.in_sleep = deep_sleep_in;
      cur_mode = s_ff.in_sleep ? s_ff.sleep_mode : s_ff.active_mode;
      // Reserved sleep code 3 is treated as off so it never turns the detector on blindly.
      det_on = running && (cur_mode != supply_monitor_pkg::MODE_OFF) &&
               !(s_ff.in_sleep && (cur_mode == supply_monitor_pkg::MODE_ON_WAIT)); // see [RULE17] see [RULE18]
      sampled = det_on && (cur_mode == supply_monitor_pkg::MODE_SAMPLED);

      // Sample period follows the rate bit. (see [RULE19])
      sample_last = s_ff.sample_rate ?
                    supply_monitor_pkg::SAMPLE_CNT_W'(SAMPLE_SLOW_CYCLES - 1) :
                    supply_monitor_pkg::SAMPLE_CNT_W'(SAMPLE_FAST_CYCLES - 1);
      nxt_s.sample_pulse = 1'b0;
      if (!sampled)
      begin
         nxt_s.sample_cnt = '0;
      end
      else if (s_ff.sample_cnt >= sample_last)
      begin
         nxt_s.sample_cnt   = '0;
         nxt_s.sample_pulse = 1'b1;
      end
      else
      begin
         nxt_s.sample_cnt = s_ff.sample_cnt + 1'b1;
      end

      // Mode 3 after wake holds the wake-up until the detector reports ready; set wins.
      if (s_ff.wake_hold && s_ff.ready_sync)
      begin
         nxt_s.wake_hold = 1'b0;
      end
      if (running && s_ff.in_sleep && !deep_sleep_in &&
          (s_ff.active_mode == supply_monitor_pkg::MODE_ON_WAIT))
      begin
         nxt_s.wake_hold = 1'b1; // see [RULE17]
      end

      // Monitor needs both the detector and its enable. (see [RULE3]) (see [RULE5])
      mon_on   = det_on && s_ff.irq_enable;
      // Sampled mode evaluates only on the detector's sample pulse. (see [RULE6])
      evaluate = det_on && (!sampled || s_ff.sample_pulse);
      // Below state only moves while the detector is on. (see [RULE23])
      if (evaluate)
      begin
         nxt_s.below_state = s_ff.below_sync;
      end
      fell = evaluate && !s_ff.below_state && s_ff.below_sync;
      rose = evaluate && s_ff.below_state && !s_ff.below_sync;

      trigger = 1'b0;
      if (mon_on && sampled)
      begin
         trigger = (s_ff.direction == supply_monitor_pkg::DIR_RISE) && rose; // see [RULE9]
      end
      else if (mon_on)
      begin
         case (s_ff.direction) // see [RULE4] see [RULE22]
            supply_monitor_pkg::DIR_FALL:   trigger = fell;
            supply_monitor_pkg::DIR_RISE:   trigger = rose;
            supply_monitor_pkg::DIR_EITHER: trigger = fell || rose;
            default:                        trigger = 1'b0;
         endcase
      end

      // Register writes; unmapped offsets are ignored.
      enable_set = 1'b0;
      flag_clear = 1'b0;
      if (s_ff.unlock_cnt != 3'h0)
      begin
         nxt_s.unlock_cnt = s_ff.unlock_cnt - 3'h1;
      end
      if (wr_strobe_in && running)
      begin
         case (addr_in)
            supply_monitor_pkg::OFS_DETECTOR_MODE_CONTROL:
            begin
               // Only the sleep field is writable, and only inside the unlock window.
               if (s_ff.unlock_cnt != 3'h0)
               begin
                  nxt_s.sleep_mode = wr_data_in[supply_monitor_pkg::SLEEP_LSB +: 2]; // see [RULE15]
                  nxt_s.unlock_cnt = 3'h0;
               end
               // Trip level, active mode and rate are never taken from the bus. (see [RULE2]) (see [RULE16])
            end
            supply_monitor_pkg::OFS_MONITOR_LEVEL_CONTROL:
            begin
               nxt_s.margin = wr_data_in[supply_monitor_pkg::MARGIN_LSB +: 2]; // see [RULE8]
            end
            supply_monitor_pkg::OFS_MONITOR_INTERRUPT_CONTROL:
            begin
               nxt_s.irq_enable = wr_data_in[supply_monitor_pkg::IRQ_ENABLE_BIT]; // see [RULE3]
               nxt_s.direction  = wr_data_in[supply_monitor_pkg::DIRECTION_LSB +: 2];
               enable_set = det_on && !s_ff.irq_enable &&
                            wr_data_in[supply_monitor_pkg::IRQ_ENABLE_BIT] &&
                            (wr_data_in[supply_monitor_pkg::DIRECTION_LSB +: 2] ==
                             supply_monitor_pkg::DIR_EITHER); // see [RULE7]
            end
            supply_monitor_pkg::OFS_MONITOR_INTERRUPT_FLAG:
            begin
               flag_clear = wr_data_in[supply_monitor_pkg::FLAG_BIT]; // see [RULE24]
            end
            default:
            begin
               flag_clear = 1'b0;
            end
         endcase
      end
      // A key arriving now opens a fresh window for the following cycles.
      if (register_unlock_key_in)
      begin
         nxt_s.unlock_cnt = supply_monitor_pkg::UNLOCK_WINDOW; // see [RULE15]
      end

      // A new event in the clearing cycle survives the clear. (see [RULE10]) (see [RULE24])
      nxt_s.flag = (s_ff.flag && !flag_clear) || trigger || enable_set;

      // Halt only masks the request; flag and detector keep running. (see [RULE11]) (see [RULE12])
      nxt_s.irq_req    = nxt_s.irq_enable && nxt_s.flag && !debug_halt_in;
      nxt_s.det_active = det_on;
      nxt_s.mon_active = mon_on;

      nxt_s.rd_data = 8'h00;
      if (rd_strobe_in)
      begin
         case (addr_in)
            supply_monitor_pkg::OFS_DETECTOR_MODE_CONTROL:
            begin
               nxt_s.rd_data[supply_monitor_pkg::SAMPLE_RATE_BIT]   = s_ff.sample_rate;
               nxt_s.rd_data[supply_monitor_pkg::ACTIVE_LSB +: 2]  = s_ff.active_mode;
               nxt_s.rd_data[supply_monitor_pkg::SLEEP_LSB +: 2]   = s_ff.sleep_mode;
            end
            supply_monitor_pkg::OFS_DETECTOR_THRESHOLD:
            begin
               nxt_s.rd_data[supply_monitor_pkg::LEVEL_LSB +: 3] = s_ff.trip_level; // see [RULE20]
            end
            supply_monitor_pkg::OFS_MONITOR_LEVEL_CONTROL:
            begin
               nxt_s.rd_data[supply_monitor_pkg::MARGIN_LSB +: 2] = s_ff.margin;
            end
            supply_monitor_pkg::OFS_MONITOR_INTERRUPT_CONTROL:
            begin
               nxt_s.rd_data[supply_monitor_pkg::IRQ_ENABLE_BIT]     = s_ff.irq_enable;
               nxt_s.rd_data[supply_monitor_pkg::DIRECTION_LSB +: 2] = s_ff.direction;
            end
            supply_monitor_pkg::OFS_MONITOR_INTERRUPT_FLAG:
            begin
               nxt_s.rd_data[supply_monitor_pkg::FLAG_BIT] = s_ff.flag;
            end
            supply_monitor_pkg::OFS_MONITOR_LEVEL_STATE:
            begin
               nxt_s.rd_data[supply_monitor_pkg::BELOW_BIT] = s_ff.below_state; // see [RULE23]
            end
            default:
            begin
               nxt_s.rd_data = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         s_ff           <= '0;
         s_ff.phase     <= supply_monitor_pkg::LOAD_SYNC1;
         s_ff.margin    <= supply_monitor_pkg::MARGIN_RESET;
         s_ff.direction <= supply_monitor_pkg::DIRECTION_RESET;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign rd_data_out         = s_ff.rd_data;
   assign detector_enable_out = s_ff.det_active;
   assign detector_sample_out = s_ff.sample_pulse;
   assign trip_level_sel_out  = s_ff.trip_level;
   assign warn_margin_sel_out = s_ff.margin;
   assign warn_monitor_on_out = s_ff.mon_active;
   assign wake_hold_out       = s_ff.wake_hold;
   assign warn_irq_out        = s_ff.irq_req;

endmodule : supply_monitor_control
`default_nettype wire

// *** tb/supply_monitor_control_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_control_props
#(
   parameter int unsigned SAMPLE_FAST_CYCLES = 8,
   parameter int unsigned SAMPLE_SLOW_CYCLES = 16
)
(
   input wire logic       core_clk_in,
   input wire logic       resetn_in,
   input wire logic [7:0] detector_fuse_byte_in,
   input wire logic       debug_halt_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic       wr_strobe_in,
   input wire logic       rd_strobe_in,
   input wire logic [7:0] rd_data_out,
   input wire logic       detector_enable_out,
   input wire logic       detector_sample_out,
   input wire logic [2:0] trip_level_sel_out,
   input wire logic [1:0] warn_margin_sel_out,
   input wire logic       warn_monitor_on_out,
   input wire logic       warn_irq_out
);
   logic [1:0] wr_low;
   assign wr_low = wr_data_in[1:0];
   default clocking dc @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_trip;
      trip_level_sel_out == 3'h0 || trip_level_sel_out == detector_fuse_byte_in[7:5];
   endproperty
   a_trip: assert property (p_trip) else $error("trip level not from fuse");
   property p_rd_level;
      $past(rd_strobe_in) && $past(addr_in) == 4'h1
         |-> rd_data_out == {5'h00, $past(trip_level_sel_out)};
   endproperty
   a_rd_level: assert property (p_rd_level) else $error("trip level read wrong");
   property p_margin_wr;
      wr_strobe_in && addr_in == 4'h8 |=> warn_margin_sel_out == $past(wr_low);
   endproperty
   a_margin_wr: assert property (p_margin_wr) else $error("margin not written");
   property p_margin_rd;
      $past(rd_strobe_in) && $past(addr_in) == 4'h8
         |-> rd_data_out == {6'h00, $past(warn_margin_sel_out)};
   endproperty
   a_margin_rd: assert property (p_margin_rd) else $error("margin read wrong");
   property p_irq_halt;
      warn_irq_out |-> !$past(debug_halt_in);
   endproperty
   a_irq_halt: assert property (p_irq_halt) else $error("request during halt");
   // A write to offset 9 or A, or a halt, may drop the request at the next edge, so only cycles with no write at any offset and no halt are held to it.
   property p_irq_stands;
      warn_irq_out && !wr_strobe_in && !debug_halt_in |=> warn_irq_out;
   endproperty
   a_irq_stands: assert property (p_irq_stands) else $error("request dropped");
   property p_clear;
      wr_strobe_in && addr_in == 4'hA && wr_data_in[0] && !warn_monitor_on_out
         |=> !warn_irq_out;
   endproperty
   a_clear: assert property (p_clear) else $error("flag clear ignored");
   property p_sample_gap;
      detector_sample_out |=> !detector_sample_out [*7];
   endproperty
   a_sample_gap: assert property (p_sample_gap) else $error("samples too close");
   property p_sample_on;
      detector_sample_out |-> detector_enable_out;
   endproperty
   a_sample_on: assert property (p_sample_on) else $error("sample while off");
   property p_mon_follows;
      warn_monitor_on_out |-> detector_enable_out;
   endproperty
   a_mon_follows: assert property (p_mon_follows) else $error("monitor on while off");
endmodule : supply_monitor_control_props

bind supply_monitor_control supply_monitor_control_props #(
   .SAMPLE_FAST_CYCLES(SAMPLE_FAST_CYCLES), .SAMPLE_SLOW_CYCLES(SAMPLE_SLOW_CYCLES)) u_props (
   .core_clk_in(core_clk_in), .resetn_in(resetn_in), .debug_halt_in(debug_halt_in),
   .detector_fuse_byte_in(detector_fuse_byte_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
   .detector_enable_out(detector_enable_out), .detector_sample_out(detector_sample_out),
   .trip_level_sel_out(trip_level_sel_out), .warn_margin_sel_out(warn_margin_sel_out),
   .warn_monitor_on_out(warn_monitor_on_out), .warn_irq_out(warn_irq_out));
`default_nettype wire

// *** tb/supply_monitor_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_control_test;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] fuse = 8'hE6;
   logic       below = 1'b0;
   logic       ready = 1'b0;
   logic       sleep = 1'b0;
   logic       halt = 1'b0;
   logic       key = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic [2:0] lvl;
   logic [1:0] mgn;
   logic       det_en, det_smp, mon_on, hold, irq;
   int         miscompares = 0;
   int         cmp_count = 0;

   always #5 clk = ~clk;

   supply_monitor_control #(.SAMPLE_FAST_CYCLES(8), .SAMPLE_SLOW_CYCLES(16)) dut (
      .core_clk_in(clk), .resetn_in(rstn), .detector_fuse_byte_in(fuse),
      .warn_below_raw_in(below), .detector_ready_raw_in(ready), .deep_sleep_in(sleep),
      .debug_halt_in(halt), .register_unlock_key_in(key), .addr_in(addr), .wr_data_in(wdata),
      .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata), .detector_enable_out(det_en),
      .detector_sample_out(det_smp), .trip_level_sel_out(lvl), .warn_margin_sel_out(mgn),
      .warn_monitor_on_out(mon_on), .wake_hold_out(hold), .warn_irq_out(irq));

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   task automatic unlock;
      @(posedge clk);
      key <= 1'b1;
      @(posedge clk);
      key <= 1'b0;
   endtask : unlock

   task automatic do_reset(input logic [7:0] f);
      @(posedge clk);
      rstn <= 1'b0;
      fuse <= f;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      cyc(5);
   endtask : do_reset

   // Measures the distance between two sample pulses; both waits are bounded.
   task automatic gap_chk(input int exp);
      int n;
      n = 0;
      while (det_smp !== 1'b1 && n < 40)
      begin
         cyc(1);
         n++;
      end
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end while (det_smp !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         miscompares++;
         final_report();
      end
      chk(8'(n), 8'(exp));
   endtask : gap_chk

   initial
   begin
      do_reset(8'hE6);
      rd_chk(4'h0, 8'h06);
      rd_chk(4'h1, 8'h07);
      chk({5'h00, lvl}, 8'h07);
      for (int i = 8; i < 12; i++)
         rd_chk(4'(i), 8'h00);
      rd_chk(4'h3, 8'h00);
      wr_reg(4'h1, 8'h00);
      wr_reg(4'h0, 8'hFF);
      rd_chk(4'h1, 8'h07);
      rd_chk(4'h0, 8'h06);
      for (int m = 0; m < 3; m++)
      begin
         wr_reg(4'h8, 8'(m));
         rd_chk(4'h8, 8'(m));
         chk({6'h00, mgn}, 8'(m));
      end
      wr_reg(4'h9, 8'h01);
      cyc(1);
      chk({7'h00, mon_on}, 8'h01);
      @(posedge clk);
      sleep <= 1'b1;
      gap_chk(8);
      @(posedge clk);
      below <= 1'b1;
      cyc(30);
      rd_chk(4'hB, 8'h01);
      rd_chk(4'hA, 8'h00);
      wr_reg(4'h9, 8'h03);
      @(posedge clk);
      below <= 1'b0;
      cyc(30);
      rd_chk(4'hA, 8'h01);
      wr_reg(4'hA, 8'h01);
      @(posedge clk);
      sleep <= 1'b0;
      cyc(3);
      chk({6'h00, det_smp, det_en}, 8'h01);
      wr_reg(4'h9, 8'h01);
      rd_chk(4'hA, 8'h00);
      @(posedge clk);
      below <= 1'b1;
      cyc(6);
      rd_chk(4'hA, 8'h01);
      rd_chk(4'hB, 8'h01);
      chk({7'h00, irq}, 8'h01);
      @(posedge clk);
      halt <= 1'b1;
      cyc(2);
      chk({7'h00, irq}, 8'h00);
      @(posedge clk);
      halt <= 1'b0;
      wr_reg(4'hA, 8'h00);
      rd_chk(4'hA, 8'h01);
      wr_reg(4'hA, 8'h01);
      @(posedge clk);
      below <= 1'b0;
      cyc(6);
      rd_chk(4'hA, 8'h00);
      wr_reg(4'h9, 8'h00);
      wr_reg(4'h9, 8'h05);
      rd_chk(4'hA, 8'h01);
      unlock();
      wr_reg(4'h0, 8'h00);
      rd_chk(4'h0, 8'h04);
      @(posedge clk);
      sleep <= 1'b1;
      cyc(3);
      chk({6'h00, mon_on, det_en}, 8'h00);
      chk({7'h00, irq}, 8'h01);
      wr_reg(4'hA, 8'h01);
      below <= 1'b1;
      cyc(6);
      chk({7'h00, irq}, 8'h00);
      rd_chk(4'hB, 8'h00);
      @(posedge clk);
      sleep <= 1'b0;
      unlock();
      cyc(6);
      wr_reg(4'h0, 8'h02);
      rd_chk(4'h0, 8'h04);
      do_reset(8'h3B);
      rd_chk(4'h0, 8'h1B);
      rd_chk(4'h8, 8'h00);
      gap_chk(16);
      @(posedge clk);
      sleep <= 1'b1;
      cyc(3);
      chk({7'h00, det_en}, 8'h00);
      do_reset(8'h3C);
      rd_chk(4'h1, 8'h01);
      @(posedge clk);
      sleep <= 1'b0;
      cyc(3);
      chk({7'h00, hold}, 8'h01);
      @(posedge clk);
      ready <= 1'b1;
      cyc(5);
      chk({7'h00, hold}, 8'h00);
      final_report();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report();
   end
endmodule : supply_monitor_control_test
`default_nettype wire
